// [include/srh_defs.svh]
// timing counts, reset values and widths shared by both reset ends
`ifndef SRH_DEFS_SVH
`define SRH_DEFS_SVH

// ==========================================================
// clock
// ==========================================================
`define CLK_SYS_MHZ          10

// ==========================================================
// reset timing
// ==========================================================
// least low time of the reset line in normal operation, in us
`define RST_MIN_PULSE_US     92
// least time rounds up; us times MHz is already a whole count
`define RST_MIN_PULSE_CYCLES (`RST_MIN_PULSE_US * `CLK_SYS_MHZ)
// boot oscillator start-up cover after power-up, in us
`define OSC_STARTUP_US       2000
`define OSC_STARTUP_CYCLES   (`OSC_STARTUP_US * `CLK_SYS_MHZ)
// width of the controller hold counter
`define HOLD_CNT_W           24

// ==========================================================
// device reset values, widths and fetch step
// ==========================================================
`define PC_RESET             32'h0000_0000
`define CPSR_RESET           32'h0000_00d3
`define UI_REG_RESET         32'h0000_0000
`define UI_RDATA_RESET       32'h0000_0000
`define UI_ADDR_W            3
`define BOOT_STRAP_W         4
// fetch address step per instruction, in bytes
`define FETCH_STEP           32'h0000_0004

`endif

// [include/srh_pkg.sv]
// types shared by the device end and the reset controller end
package srh_pkg;

  // ========================================================
  // data words
  // ========================================================
  typedef logic [31:0] srh_word_t;

  // ========================================================
  // debug test access port states
  // ========================================================
  typedef enum logic [3:0] {
    TAP_RESET,
    TAP_IDLE,
    TAP_SEL_DR,
    TAP_CAP_DR,
    TAP_SHIFT_DR,
    TAP_EXIT1_DR,
    TAP_PAUSE_DR,
    TAP_EXIT2_DR,
    TAP_UPD_DR,
    TAP_SEL_IR,
    TAP_CAP_IR,
    TAP_SHIFT_IR,
    TAP_EXIT1_IR,
    TAP_PAUSE_IR,
    TAP_EXIT2_IR,
    TAP_UPD_IR
  } srh_tap_state_t;

  // ========================================================
  // reset controller states
  // ========================================================
  typedef enum logic [1:0] {
    CTL_COLD_HOLD,
    CTL_USER_HOLD,
    CTL_RUN
  } srh_ctl_state_t;

endpackage

// [include/srh_reset_if.sv]
// system reset line between the reset controller and the device
`timescale 1ns/1ns
interface srh_reset_if;
  // active-low system reset, driven by the controller
  logic system_reset_in_n;

  modport ctrl (output system_reset_in_n);
  modport dev  (input  system_reset_in_n);
endinterface // srh_reset_if

// [src/srh_device_end.sv]
// device end: reacts to the system reset line
// Notes on behaviour
// RULE1 - reset line active low, resets logic asynchronously
// RULE2 - reset restores registers, samples boot configuration
// RULE3 - fetch restarts at address zero
// RULE4 - reset line also resets debug TAP
// RULE5 - release is synchronised to the system clock
// RULE6 - controller holds reset low 92 us minimum
// RULE7 - processor stops at once, clock irrelevant
// RULE8 - only PC and CPSR get reset values
// RULE9 - power-up hold covers oscillator start-up
// RULE10 - cold and user resets act alike
// RULE11 - manual command gives shorter hold than power-up
// RULE12 - controller also resets on power-down, brownout
// RULE13 - new request restarts the controller hold timer; in a cold hold it is reloaded only when less than a user hold is left
`timescale 1ns/1ns
`include "srh_defs.svh"
module srh_device_end #(
  parameter int UI_AW   = `UI_ADDR_W,    // user register address bits
  parameter int STRAP_W = `BOOT_STRAP_W  // boot strap width
) (
  input  wire logic                clk_sys,
  input  wire logic                rst,
  srh_reset_if.dev                 rst_link,
  input  wire logic [STRAP_W-1:0]  boot_strap,
  input  wire logic                cpu_step,
  input  wire logic                cpu_branch,
  input  wire logic                cpu_psr_wr,
  input  srh_pkg::srh_word_t       cpu_wdata,
  input  wire logic                ui_wr_en,
  input  wire logic [UI_AW-1:0]    ui_addr,
  input  srh_pkg::srh_word_t       ui_wdata,
  input  wire logic                tap_tck_en,
  input  wire logic                tap_tms,
  input  wire logic                tap_tdi,
  output logic                     core_run_q,
  output srh_pkg::srh_word_t       fetch_addr_q,
  output srh_pkg::srh_word_t       cpsr_q,
  output srh_pkg::srh_word_t       ui_rdata_q,
  output logic [STRAP_W-1:0]       boot_cfg_q,
  output logic                     tap_tdo_q,
  output logic                     tap_reset_q
);
  import srh_pkg::*;

  localparam int NUM_UI = 1 << UI_AW;  // user register count

  // ========================================================
  // reset release synchroniser
  // ========================================================
  logic       rel_meta_q;   // first stage, read only by the second
  logic       rel_sync_q;   // release, aligned to clk_sys
  wire  logic pin_rst_n;    // raw reset line
  wire  logic hold_core;    // logic held in reset this cycle

  assign pin_rst_n = rst_link.system_reset_in_n;

  // the line may drop at any time; only its rise is re-timed
  always_ff @(posedge clk_sys or negedge pin_rst_n) begin
    if (!pin_rst_n) begin          // [RULE1]
      rel_meta_q <= 1'b0;
      rel_sync_q <= 1'b0;
    end else begin
      rel_meta_q <= 1'b1;          // [RULE5]
      rel_sync_q <= rel_meta_q;
    end
  end

  // cold and user resets arrive on the same line, same effect
  assign hold_core = rst | ~rel_sync_q;  // [RULE10]

  // ========================================================
  // boot configuration capture
  // ========================================================
  // sampled on every edge while held, frozen at release;
  // no async clear here since the value must come from pins
  always_ff @(posedge clk_sys) begin
    if (hold_core) begin
      boot_cfg_q <= boot_strap;    // [RULE2]
    end
  end

  // ========================================================
  // processor run state and fetch address
  // ========================================================
  wire srh_word_t branch_addr;  // branch target, word aligned
  wire srh_word_t step_addr;    // next sequential fetch
  wire srh_word_t fetch_d;      // next fetch address

  assign branch_addr = {cpu_wdata[31:2], 2'b00};
  assign step_addr   = fetch_addr_q + `FETCH_STEP;
  assign fetch_d     = cpu_branch ? branch_addr :
                       cpu_step   ? step_addr   : fetch_addr_q;

  // run drops the moment the line drops, without a clock edge
  always_ff @(posedge clk_sys or negedge pin_rst_n) begin
    if (!pin_rst_n) begin
      core_run_q <= 1'b0;          // [RULE7]
    end else begin
      core_run_q <= ~hold_core;    // [RULE5]
    end
  end

  // only fetch address and status word are given reset values;
  // the rest of the processor state is left as it comes up
  always_ff @(posedge clk_sys or negedge pin_rst_n) begin
    if (!pin_rst_n) begin
      fetch_addr_q <= `PC_RESET;   // [RULE3] [RULE8]
      cpsr_q       <= `CPSR_RESET; // [RULE8]
    end else if (hold_core) begin
      fetch_addr_q <= `PC_RESET;   // [RULE3]
      cpsr_q       <= `CPSR_RESET;
    end else if (core_run_q) begin
      fetch_addr_q <= fetch_d;
      if (cpu_psr_wr) begin
        cpsr_q <= cpu_wdata;
      end
    end
  end

  // ========================================================
  // peripheral user-interface registers
  // ========================================================
  srh_word_t ui_regs_q [NUM_UI];  // register bank
  wire srh_word_t ui_rdata_d;     // selected register

  // writes are refused until the core runs again
  genvar gi;
  generate
    for (gi = 0; gi < NUM_UI; gi++) begin : g_ui
      wire logic hit;  // this register addressed for write
      assign hit = ui_wr_en && core_run_q &&
                   (ui_addr == UI_AW'(gi));
      always_ff @(posedge clk_sys or negedge pin_rst_n) begin
        if (!pin_rst_n) begin
          ui_regs_q[gi] <= `UI_REG_RESET;  // [RULE2]
        end else if (hold_core) begin
          ui_regs_q[gi] <= `UI_REG_RESET;  // [RULE2]
        end else if (hit) begin
          ui_regs_q[gi] <= ui_wdata;
        end
      end
    end
  endgenerate

  assign ui_rdata_d = ui_regs_q[ui_addr];

  // read data is registered so the output is a flop
  always_ff @(posedge clk_sys or negedge pin_rst_n) begin
    if (!pin_rst_n) begin
      ui_rdata_q <= `UI_RDATA_RESET;
    end else if (hold_core) begin
      ui_rdata_q <= `UI_RDATA_RESET;
    end else begin
      ui_rdata_q <= ui_rdata_d;
    end
  end

  // ========================================================
  // debug test access port
  // ========================================================
  srh_tap_state_t tap_state_q;  // current TAP state
  srh_tap_state_t tap_next;     // state after a test clock
  logic           bypass_q;     // one-bit data path

  // standard 16-state walk, decided by tms on each test clock
  function automatic srh_tap_state_t tap_step(
    input srh_tap_state_t st,
    input logic           tms
  );
    case (st)
      TAP_RESET:    tap_step = tms ? TAP_RESET    : TAP_IDLE;
      TAP_IDLE:     tap_step = tms ? TAP_SEL_DR   : TAP_IDLE;
      TAP_SEL_DR:   tap_step = tms ? TAP_SEL_IR   : TAP_CAP_DR;
      TAP_CAP_DR:   tap_step = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_SHIFT_DR: tap_step = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_EXIT1_DR: tap_step = tms ? TAP_UPD_DR   : TAP_PAUSE_DR;
      TAP_PAUSE_DR: tap_step = tms ? TAP_EXIT2_DR : TAP_PAUSE_DR;
      TAP_EXIT2_DR: tap_step = tms ? TAP_UPD_DR   : TAP_SHIFT_DR;
      TAP_UPD_DR:   tap_step = tms ? TAP_SEL_DR   : TAP_IDLE;
      TAP_SEL_IR:   tap_step = tms ? TAP_RESET    : TAP_CAP_IR;
      TAP_CAP_IR:   tap_step = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_SHIFT_IR: tap_step = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_EXIT1_IR: tap_step = tms ? TAP_UPD_IR   : TAP_PAUSE_IR;
      TAP_PAUSE_IR: tap_step = tms ? TAP_EXIT2_IR : TAP_PAUSE_IR;
      TAP_EXIT2_IR: tap_step = tms ? TAP_UPD_IR   : TAP_SHIFT_IR;
      TAP_UPD_IR:   tap_step = tms ? TAP_SEL_DR   : TAP_IDLE;
      default:      tap_step = TAP_RESET;
    endcase
  endfunction

  assign tap_next = tap_step(tap_state_q, tap_tms);

  // the system line resets the TAP too, not only the tms walk;
  // trade-off: a debugger cannot hold the core across reset
  always_ff @(posedge clk_sys or negedge pin_rst_n) begin
    if (!pin_rst_n) begin
      tap_state_q <= TAP_RESET;    // [RULE4]
      bypass_q    <= 1'b0;
      tap_tdo_q   <= 1'b0;
      tap_reset_q <= 1'b1;
    end else if (rst) begin
      tap_state_q <= TAP_RESET;    // [RULE4]
      bypass_q    <= 1'b0;
      tap_tdo_q   <= 1'b0;
      tap_reset_q <= 1'b1;
    end else if (tap_tck_en) begin
      tap_state_q <= tap_next;
      tap_reset_q <= (tap_next == TAP_RESET);
      // shift through the bypass bit only in shift-dr
      if (tap_state_q == TAP_SHIFT_DR) begin
        bypass_q  <= tap_tdi;
        tap_tdo_q <= bypass_q;
      end
    end
  end

endmodule // srh_device_end

// [src/srh_reset_ctrl.sv]
// controller end: drives the system reset line
`timescale 1ns/1ns
`include "srh_defs.svh"
module srh_reset_ctrl #(
  // long counts are parameters so simulation can shorten them
  parameter int COLD_HOLD_CYCLES = `OSC_STARTUP_CYCLES,
  parameter int USER_HOLD_CYCLES = `RST_MIN_PULSE_CYCLES
) (
  input  wire logic clk_sys,
  input  wire logic rst,
  srh_reset_if.ctrl rst_link,
  input  wire logic power_good,
  input  wire logic brownout,
  input  wire logic manual_req,
  output logic      reset_active_q,
  output logic      cold_phase_q
);
  import srh_pkg::*;

  localparam int CW = `HOLD_CNT_W;
  localparam logic [CW-1:0] COLD_CNT = CW'(COLD_HOLD_CYCLES);
  localparam logic [CW-1:0] USER_CNT = CW'(USER_HOLD_CYCLES);
  localparam logic [CW-1:0] ONE_CNT  = {{(CW-1){1'b0}}, 1'b1};

  // ========================================================
  // state
  // ========================================================
  srh_ctl_state_t  state_q;     // hold phase
  logic [CW-1:0]   hold_cnt_q;  // cycles of low left
  logic            rst_n_q;     // line level, flop driven

  wire logic supply_bad;  // supply under threshold
  wire logic hold_done;   // last cycle of the hold
  wire logic user_short;  // remaining hold below a user hold

  // ========================================================
  // decode
  // ========================================================
  assign supply_bad = ~power_good | brownout;  // [RULE12]
  assign hold_done  = (hold_cnt_q == ONE_CNT);
  assign user_short = (hold_cnt_q < USER_CNT);

  // ========================================================
  // hold sequencer
  // ========================================================
  // low time equals the loaded count, one cycle per count
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_q    <= CTL_COLD_HOLD;  // [RULE9]
      hold_cnt_q <= COLD_CNT;
      rst_n_q    <= 1'b0;
    end else if (supply_bad) begin
      // power-up, power-down or brownout: full cold hold
      state_q    <= CTL_COLD_HOLD;  // [RULE12] [RULE9]
      hold_cnt_q <= COLD_CNT;
      rst_n_q    <= 1'b0;
    end else if (manual_req) begin
      rst_n_q <= 1'b0;              // [RULE11]
      case (state_q)
        CTL_COLD_HOLD: begin
          // a cold hold in progress is never shortened
          if (user_short) begin
            hold_cnt_q <= USER_CNT; // [RULE13]
          end
        end
        default: begin
          state_q    <= CTL_USER_HOLD;
          hold_cnt_q <= USER_CNT;   // [RULE6] [RULE13]
        end
      endcase
    end else begin
      case (state_q)
        CTL_COLD_HOLD,
        CTL_USER_HOLD: begin
          if (hold_done) begin
            state_q <= CTL_RUN;
            rst_n_q <= 1'b1;
          end else begin
            hold_cnt_q <= hold_cnt_q - ONE_CNT;
          end
        end
        CTL_RUN: begin
          rst_n_q <= 1'b1;
        end
        default: begin
          state_q    <= CTL_COLD_HOLD;
          hold_cnt_q <= COLD_CNT;
          rst_n_q    <= 1'b0;
        end
      endcase
    end
  end

  // ========================================================
  // status outputs
  // ========================================================
  // mirrors of the line so the user side needs no decode
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      reset_active_q <= 1'b1;
      cold_phase_q   <= 1'b1;
    end else begin
      reset_active_q <= supply_bad | manual_req |
                        (state_q != CTL_RUN && !hold_done);
      cold_phase_q   <= supply_bad |
                        (state_q == CTL_COLD_HOLD && !hold_done);
    end
  end

  assign rst_link.system_reset_in_n = rst_n_q;

endmodule // srh_reset_ctrl

// [verification/srh_asserts.sv]
// concurrent checks on the reset line and both reset ends
`timescale 1ns/1ns
`include "srh_defs.svh"
module srh_asserts #(
  parameter int COLD_HOLD_CYCLES = 50,  // power-up hold, cycles
  parameter int USER_HOLD_CYCLES = 20   // user hold, cycles
) (
  input wire logic          clk_sys,
  input wire logic          rst,
  input wire logic          system_reset_in_n,
  input wire logic          power_good,
  input wire logic          brownout,
  input wire logic          manual_req,
  input wire logic [3:0]    boot_strap,
  input wire logic          core_run_q,
  input srh_pkg::srh_word_t fetch_addr_q,
  input srh_pkg::srh_word_t cpsr_q,
  input srh_pkg::srh_word_t ui_rdata_q,
  input wire logic [3:0]    boot_cfg_q,
  input wire logic          tap_reset_q,
  input wire logic          reset_active_q,
  input wire logic          cold_phase_q
);
  import srh_pkg::*;
  // ==========================================================
  // helper counters
  // ==========================================================
  int low_q;   // cycles the line has been sampled low
  int good_q;  // cycles of healthy supply since the last fault
  // plain counters; a run stays far below their range
  always_ff @(posedge clk_sys) begin
    low_q  <= system_reset_in_n ? 0 : low_q + 1;
    good_q <= (rst || !power_good || brownout) ? 0 : good_q + 1;
  end
  // ==========================================================
  // properties
  // ==========================================================
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence s_still_held;  // core stays halted two edges
    !core_run_q [*2];
  endsequence
  chk_core_halts: assert property (
    !system_reset_in_n |-> !core_run_q)
    else $error("core runs while the line is low");
  chk_fetch_zero: assert property (
    !system_reset_in_n |-> fetch_addr_q == `PC_RESET)
    else $error("fetch address not zero in reset");
  chk_status_value: assert property (
    !system_reset_in_n |-> cpsr_q == `CPSR_RESET)
    else $error("status word wrong in reset");
  chk_ui_cleared: assert property (
    !system_reset_in_n |-> ui_rdata_q == `UI_RDATA_RESET)
    else $error("user read data not cleared");
  chk_tap_reset: assert property (
    !system_reset_in_n |-> tap_reset_q)
    else $error("debug port not in reset");
  chk_boot_sample: assert property (
    !system_reset_in_n ##1 !system_reset_in_n |->
      boot_cfg_q == $past(boot_strap))
    else $error("boot pins not sampled");
  chk_sync_release: assert property (
    $rose(system_reset_in_n) |-> s_still_held ##[1:2] core_run_q)
    else $error("release not synchronised");
  chk_user_width: assert property (
    $rose(system_reset_in_n) |-> low_q >= USER_HOLD_CYCLES - 1)
    else $error("reset pulse too short");
  chk_cold_cover: assert property (
    $rose(system_reset_in_n) |-> good_q >= COLD_HOLD_CYCLES - 1)
    else $error("cold hold too short");
  chk_manual_take: assert property (
    manual_req |=> !system_reset_in_n && reset_active_q)
    else $error("manual request not taken");
  chk_supply_fault: assert property (
    !power_good || brownout |=> !system_reset_in_n && cold_phase_q)
    else $error("supply fault not taken");
endmodule // srh_asserts

// [verification/tb_top.sv]
// bench joining the reset controller and the device end
`timescale 1ns/1ns
`include "srh_defs.svh"
module tb_top;
  import srh_pkg::*;
  // ==========================================================
  // setup
  // ==========================================================
  localparam int COLD  = 50;    // shortened power-up hold
  localparam int USER  = 20;    // shortened user hold
  localparam int LIMIT = 6000;  // whole run fits well inside
  typedef struct {
    logic [2:0] addr;  // user register
    srh_word_t  data;  // written, then read back
  } srh_row_t;
  srh_row_t rows[4] = '{'{3'h0, 32'h1111_2222}, '{3'h7, 32'hffff_ffff},
                        '{3'h2, 32'h0000_0001}, '{3'h5, 32'ha5a5_5a5a}};
  logic       clk_sys = 1'b0, rst = 1'b1;
  logic       power_good = 1'b1, brownout = 1'b0, manual_req = 1'b0;
  logic [3:0] boot_strap = 4'h9;
  logic       cpu_step = 1'b0, cpu_branch = 1'b0, cpu_psr_wr = 1'b0;
  srh_word_t  cpu_wdata = 32'h0, ui_wdata = 32'h0;
  logic       ui_wr_en = 1'b0, tap_tck_en = 1'b0, tap_tms = 1'b0;
  logic       tap_tdi = 1'b0;
  logic [2:0] ui_addr = 3'h0;
  logic       core_run_q, tap_tdo_q, tap_reset_q;
  logic       reset_active_q, cold_phase_q;
  srh_word_t  fetch_addr_q, cpsr_q, ui_rdata_q;
  logic [3:0] boot_cfg_q;
  int         n_errors = 0, tests_run = 0, cyc = 0, low;
  srh_reset_if link_i ();
  srh_reset_ctrl #(.COLD_HOLD_CYCLES(COLD), .USER_HOLD_CYCLES(USER))
    srh_reset_ctrl_i (.clk_sys(clk_sys), .rst(rst), .rst_link(link_i.ctrl),
    .power_good(power_good), .brownout(brownout), .manual_req(manual_req),
    .reset_active_q(reset_active_q), .cold_phase_q(cold_phase_q));
  srh_device_end srh_device_end_i (.clk_sys(clk_sys), .rst(rst),
    .rst_link(link_i.dev), .boot_strap(boot_strap), .cpu_step(cpu_step),
    .cpu_branch(cpu_branch), .cpu_psr_wr(cpu_psr_wr), .cpu_wdata(cpu_wdata),
    .ui_wr_en(ui_wr_en), .ui_addr(ui_addr), .ui_wdata(ui_wdata),
    .tap_tck_en(tap_tck_en), .tap_tms(tap_tms), .tap_tdi(tap_tdi),
    .core_run_q(core_run_q), .fetch_addr_q(fetch_addr_q), .cpsr_q(cpsr_q),
    .ui_rdata_q(ui_rdata_q), .boot_cfg_q(boot_cfg_q),
    .tap_tdo_q(tap_tdo_q), .tap_reset_q(tap_reset_q));
  srh_asserts #(.COLD_HOLD_CYCLES(COLD), .USER_HOLD_CYCLES(USER))
    srh_asserts_i (.clk_sys(clk_sys), .rst(rst),
    .system_reset_in_n(link_i.system_reset_in_n), .power_good(power_good),
    .brownout(brownout), .manual_req(manual_req), .boot_strap(boot_strap),
    .core_run_q(core_run_q), .fetch_addr_q(fetch_addr_q), .cpsr_q(cpsr_q),
    .ui_rdata_q(ui_rdata_q), .boot_cfg_q(boot_cfg_q),
    .tap_reset_q(tap_reset_q), .reset_active_q(reset_active_q),
    .cold_phase_q(cold_phase_q));
  // ==========================================================
  // clock and hang guard
  // ==========================================================
  always #50 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin  // hang: count it and close
      n_errors++;
      conclude();
    end
  end
  // ==========================================================
  // tasks
  // ==========================================================
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);  // inputs move at falling edges
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic pulse_manual();  // one-cycle request, halt seen at once
    manual_req = 1'b1;
    @(posedge clk_sys);
    #1;
    check(core_run_q, 1'b0);
    check(reset_active_q, 1'b1);
    tick(1);
    manual_req = 1'b0;
  endtask
  task automatic tap_clk(input logic tms, input logic tdi);  // enable stays up
    tap_tms = tms;
    tap_tdi = tdi;
    tap_tck_en = 1'b1;
    tick(1);
  endtask
  task automatic hold_low(output int n);  // falling edges with line low
    n = 0;
    while (link_i.system_reset_in_n !== 1'b1 && n < 500) begin
      tick(1);
      n++;
    end
  endtask
  task automatic wait_run();  // release timing, then reset state
    int k;
    k = 0;
    while (core_run_q !== 1'b1 && k < 20) begin
      tick(1);
      k++;
    end
    // two sync stages plus the run flop: three edges after the rise
    check(k, 3);
    check(fetch_addr_q, `PC_RESET);
    check(cpsr_q, `CPSR_RESET);
    check(boot_cfg_q, boot_strap);
    check(tap_reset_q, 1'b1);
    check(tap_tdo_q, 1'b0);
    check(reset_active_q, 1'b0);
    check(cold_phase_q, 1'b0);
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // ==========================================================
  // main sequence
  // ==========================================================
  initial begin
    tick(20);
    rst = 1'b0;
    hold_low(low);
    check(low >= COLD, 1'b1);
    wait_run();
    $display("test power-up done");
    foreach (rows[i]) begin  // ordinary user register traffic
      ui_wr_en = 1'b1;
      ui_addr = rows[i].addr;
      ui_wdata = rows[i].data;
      tick(1);
      ui_wr_en = 1'b0;
      tick(2);
      check(ui_rdata_q, rows[i].data);
    end
    $display("test rows done");
    cpu_step = 1'b1;  // three steps, then branch and status write
    tick(3);
    cpu_step = 1'b0;
    check(fetch_addr_q, 3 * `FETCH_STEP);
    cpu_branch = 1'b1;
    cpu_psr_wr = 1'b1;
    cpu_wdata = 32'h0000_1237;
    tick(1);
    cpu_branch = 1'b0;
    cpu_psr_wr = 1'b0;
    check(fetch_addr_q, 32'h0000_1234);
    check(cpsr_q, 32'h0000_1237);
    tap_clk(1'b0, 1'b0);  // one step with tms low leaves test reset
    check(tap_reset_q, 1'b0);
    tap_clk(1'b1, 1'b0);  // idle, select, capture, then shift
    tap_clk(1'b0, 1'b0);
    tap_clk(1'b0, 1'b0);
    tap_clk(1'b0, 1'b1);  // a one enters the bypass stage
    tap_clk(1'b0, 1'b1);  // and reaches the output a clock later
    tap_tck_en = 1'b0;
    check(tap_tdo_q, 1'b1);
    $display("test core done");
    pulse_manual();  // mid-run reset with writes knocking
    cpu_step = 1'b1;
    ui_wr_en = 1'b1;
    ui_wdata = 32'h0000_00ff;
    boot_strap = 4'h6;
    hold_low(low);
    check(low, USER);
    wait_run();
    cpu_step = 1'b0;
    ui_wr_en = 1'b0;
    tick(2);
    check(ui_rdata_q, `UI_REG_RESET);
    $display("test user reset done");
    pulse_manual();  // second request restarts the hold
    tick(8);
    pulse_manual();
    hold_low(low);
    check(low, USER);
    wait_run();
    $display("test retrigger done");
    for (int c = 0; c < 2; c++) begin  // supply loss, then brownout
      power_good = (c != 0);
      brownout = (c == 1);
      tick(1);
      check(link_i.system_reset_in_n, 1'b0);
      check(cold_phase_q, 1'b1);
      tick(4);
      power_good = 1'b1;
      brownout = 1'b0;
      if (c == 1) begin  // manual request must not cut the cold hold
        tick(5);
        manual_req = 1'b1;
        tick(1);
        manual_req = 1'b0;
      end
      hold_low(low);
      check(low >= COLD - 6 * c, 1'b1);
      wait_run();
    end
    $display("test supply faults done");
    conclude();
  end
endmodule // tb_top
